// ---- hw/amg_pkg.sv ----
package amg_pkg;

  localparam int unsigned NUM_MICS      = 8;
  localparam int unsigned NUM_GROUPS    = 8;
  localparam int unsigned LVL_W         = 8;
  localparam int unsigned NUM_REFS      = 20;
  localparam int unsigned CLK_HZ        = 125000000;
  localparam int unsigned HOLD_STEP_MS  = 100;
  localparam int unsigned HOLD_STEP_CYC = CLK_HZ / 1000 * HOLD_STEP_MS;

  // Register word offsets (byte address = 4 * index).
  localparam logic [7:0] REG_MIC_CFG0  = 8'h00;
  localparam logic [7:0] REG_MIC_CFG1  = 8'h08;
  localparam logic [7:0] REG_GRP_CFG   = 8'h10;
  localparam logic [7:0] REG_STATUS    = 8'h18;

  // Mic config word 0 fields.
  localparam int unsigned F_MODE_LSB    = 0;
  localparam int unsigned F_OVR_BIT     = 2;
  localparam int unsigned F_ADAPT_BIT   = 3;
  localparam int unsigned F_LSREF_BIT   = 4;
  localparam int unsigned F_GRP_LSB     = 5;
  localparam int unsigned F_DECAY_LSB   = 9;
  localparam int unsigned F_RATIO_LSB   = 16;
  localparam int unsigned F_HOLD_LSB    = 24;
  // Mic config word 1 fields.
  localparam int unsigned F_OFFATT_LSB  = 0;
  localparam int unsigned F_AMB_LSB     = 8;
  localparam int unsigned F_REF_LSB     = 16;
  // Group config fields.
  localparam int unsigned F_MAXN_LSB    = 0;
  localparam int unsigned F_FIRST_BIT   = 8;
  localparam int unsigned F_LAST_LSB    = 9;
  localparam int unsigned F_LASTMIC_LSB = 11;

  typedef enum logic [1:0] {AMG_AUTO, AMG_FORCE_ON, AMG_FORCE_OFF}
    amg_mode_t;
  typedef enum logic [1:0] {AMG_SLOW, AMG_MEDIUM, AMG_FAST} amg_decay_t;
  typedef enum logic [1:0] {AMG_LAST_ON, AMG_LAST_OFF, AMG_LAST_MIC}
    amg_last_t;

  localparam logic [3:0] GRP_NONE  = 4'hf;
  localparam logic [7:0] MAXN_ALL  = 8'hff;

  typedef struct packed {
    logic [7:0] hold;
    logic [7:0] ratio;
    logic [4:0] rsv;
    logic [1:0] decay;
    logic [3:0] grp;
    logic       lsref;
    logic       adapt;
    logic       ovr;
    logic [1:0] mode;
  } amg_mic_cfg_t;

  typedef struct packed {
    logic [7:0] rsv;
    logic [7:0] refsel;
    logic [7:0] amb;
    logic [7:0] offatt;
  } amg_mic_lvl_t;

  localparam amg_mic_cfg_t MIC_CFG_RST = '{hold: 8'h03, ratio: 8'h0f,
    rsv: 5'h00, decay: 2'h1, grp: 4'h4, lsref: 1'b1, adapt: 1'b1,
    ovr: 1'b0, mode: 2'h0};
  localparam amg_mic_lvl_t MIC_LVL_RST = '{rsv: 8'h00, refsel: 8'h00,
    amb: 8'h50, offatt: 8'h0c};
  localparam logic [31:0] GRP_CFG_RST = 32'h0000_0104;
  localparam logic [7:0]  MAX_RATIO   = 8'h32;
  localparam logic [7:0]  MAX_OFFATT  = 8'h32;
  localparam logic [7:0]  MAX_AMB     = 8'h50;
  localparam logic [7:0]  MIN_HOLD    = 8'h01;
  localparam logic [7:0]  MAX_HOLD    = 8'h50;
  localparam logic [7:0]  MAX_INT_N   = 8'h08;
  localparam logic [7:0]  MAX_GLB_N   = 8'h40;

endpackage

// ---- hw/amg_core.sv ----
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
// Function
// [R01] Each mic is auto gated, forced on, or forced off.
// [R02] Auto mics gate by level and obey group count and override.
// [R03] Forced-on mic opens only within group limit and is counted.
// [R04] Forced-off mic stays closed whatever its level.
// [R05] Override mic opening closes non-override mics of its group.
// [R06] Adaptive ambient tracks noise floor, else fixed level used.
// [R07] Fixed ambient spans -80 to 0 dB, used only without adaptation.
// [R08] Loudspeaker reference level replaces ambient while it carries audio; the code replaces it only when the reference is louder than the ambient.
// [R09] Gate opens when level beats ambient by ratio, 0..50 dB, 15 default.
// [R10] Hold keeps gate open 0.1 to 8.0 s after level drops, 0.3 default.
// [R11] Closed channel is attenuated by off amount, 0..50 dB, 12 default.
// [R12] After hold, gain ramps down at selectable decay, medium default.
// [R13] Reference chosen from 12 outputs, 4 bus refs, 4 virtual refs.
// [R14] Virtual refs combine inputs and name one tracked output.
// [R15] Four internal and four global groups; default first global.
// [R16] Ungrouped mics gate alone and affect no group.
// [R17] Group open limit 1..8 internal, up to 64 or all global, 4 default.
// [R18] First opener's received levels become the group ambient.
// [R19] Last-on keeps latest mic on; global may name one; off closes all.
// [R20] Networked units share identical global group settings.
// [R21] Hold timer restarts whenever level again beats threshold.
module amg_core
  import amg_pkg::*;
(
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_i,
  input  wire logic [7:0]                    avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [31:0]                   avs_writedata_i,
  input  wire logic [3:0]                    avs_byteenable_i,
  output logic      [31:0]                   avs_readdata_o,
  output logic                               avs_waitrequest_o,
  output logic      [1:0]                    avs_response_o,
  input  wire logic [amg_pkg::NUM_MICS*8-1:0] mic_level_i,
  input  wire logic [amg_pkg::NUM_REFS*8-1:0] ref_level_i,
  input  wire logic [amg_pkg::NUM_REFS-1:0]  ref_active_i,
  output logic      [amg_pkg::NUM_MICS-1:0]  gate_on_o,
  output logic      [amg_pkg::NUM_MICS*8-1:0] mic_atten_o
);
  import amg_pkg::*;

  // Levels are attenuation below full scale in dB: 0 loud, 255 silent.
  ////////////////////////////////////////////////////////////////////////
  amg_mic_cfg_t mcfg_q [NUM_MICS];
  amg_mic_lvl_t mlvl_q [NUM_MICS];
  logic [31:0]  gcfg_q [NUM_GROUPS];
  logic [7:0]   amb_q  [NUM_MICS];
  logic [7:0]   hold_q [NUM_MICS];
  logic [23:0]  tick_q;
  logic         ack_q;
  logic [31:0]  rdata_q;
  logic [1:0]   resp_q;
  logic [NUM_MICS-1:0] open_q;
  logic [NUM_MICS-1:0] last_q;
  logic [NUM_GROUPS-1:0] first_q;
  logic [7:0]   grp_amb_q [NUM_GROUPS];
  logic [7:0]   att_q [NUM_MICS];
  logic [NUM_MICS-1:0] want;
  logic [NUM_MICS-1:0] open_d;
  logic         tick;

  function automatic logic [31:0] wmask(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[b*8 +: 8] = n[b*8 +: 8];
    return r;
  endfunction

  function automatic logic [7:0] clip(input logic [7:0] v,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register bus: one wait state, then answer.
  wire [2:0] idx     = avs_address_i[2:0];
  // A write lands only at the edge where the master sees waitrequest low.
  wire       req     = avs_read_i | avs_write_i;
  wire       hit_m0  = (avs_address_i[7:3] == REG_MIC_CFG0[7:3]);
  wire       hit_m1  = (avs_address_i[7:3] == REG_MIC_CFG1[7:3]);
  wire       hit_g   = (avs_address_i[7:3] == REG_GRP_CFG[7:3]);
  wire       hit_st  = (avs_address_i == REG_STATUS);
  wire       hit     = hit_m0 | hit_m1 | hit_g | hit_st;
  wire       wr_go   = avs_write_i & ack_q;
  wire [31:0] gw     = wmask(gcfg_q[idx], avs_writedata_i, avs_byteenable_i);
  wire [7:0]  gmax   = (idx < 3'd4) ? MAX_INT_N : MAX_GLB_N;
  wire [7:0]  gn_raw = gw[F_MAXN_LSB +: 8];
  wire        gall   = (idx >= 3'd4) && (gn_raw == MAXN_ALL);
  wire [7:0]  gn_fix = gall ? MAXN_ALL : clip(gn_raw, 8'h01, gmax); // see [R17]
  wire [1:0]  gl_fix = (idx < 3'd4 && gw[F_LAST_LSB +: 2] == 2'(AMG_LAST_MIC))
                       ? 2'(AMG_LAST_ON) : gw[F_LAST_LSB +: 2];     // see [R19]
  wire [31:0] mw0    = wmask(mcfg_q[idx], avs_writedata_i, avs_byteenable_i);
  wire [31:0] mw1    = wmask(mlvl_q[idx], avs_writedata_i, avs_byteenable_i);
  amg_mic_cfg_t mc_n;
  amg_mic_lvl_t ml_n;

  always_comb
  begin
    mc_n = mw0;
    ml_n = mw1;
    mc_n.rsv = '0;
    ml_n.rsv = '0;
    if (mc_n.mode == 2'h3)
      mc_n.mode = 2'(AMG_AUTO);                                    // see [R01]
    mc_n.ratio  = clip(mc_n.ratio, 8'h00, MAX_RATIO);              // see [R09]
    mc_n.hold   = clip(mc_n.hold, MIN_HOLD, MAX_HOLD);             // see [R10]
    if (mc_n.decay == 2'h3)
      mc_n.decay = 2'(AMG_MEDIUM);
    if (mc_n.grp > 4'h7)
      mc_n.grp = GRP_NONE;                                         // see [R15]
    ml_n.offatt = clip(ml_n.offatt, 8'h00, MAX_OFFATT);            // see [R11]
    ml_n.amb    = clip(ml_n.amb, 8'h00, MAX_AMB);                  // see [R07]
    ml_n.refsel = clip(ml_n.refsel, 8'h00, 8'(NUM_REFS - 1));      // see [R13]
  end

  wire [31:0] rd_mux = hit_m0 ? 32'(mcfg_q[idx]) :
                       hit_m1 ? 32'(mlvl_q[idx]) :
                       hit_g  ? gcfg_q[idx] :
                       hit_st ? {16'h0000, last_q, open_q} : 32'h0000_0000;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      resp_q  <= 2'h0;
    end
    else
    begin
      ack_q   <= req & ~ack_q;
      rdata_q <= rd_mux;
      resp_q  <= hit ? 2'h0 : 2'h2;
    end
  end

  assign avs_waitrequest_o = req & ~ack_q;
  assign avs_readdata_o    = rdata_q;
  assign avs_response_o    = resp_q;

  always_ff @(posedge sys_clk_i)
  begin
    for (int m = 0; m < NUM_MICS; m++)
    begin
      if (rst_i)
      begin
        mcfg_q[m] <= MIC_CFG_RST;
        mlvl_q[m] <= MIC_LVL_RST;
      end
      else if (wr_go && 3'(m) == idx && hit_m0)
        mcfg_q[m] <= mc_n;
      else if (wr_go && 3'(m) == idx && hit_m1)
        mlvl_q[m] <= ml_n;
    end
    for (int g = 0; g < NUM_GROUPS; g++)
    begin
      if (rst_i)
        gcfg_q[g] <= GRP_CFG_RST;
      else if (wr_go && 3'(g) == idx && hit_g)
        gcfg_q[g] <= {18'h0, gw[F_LASTMIC_LSB +: 3], gl_fix,
                      gw[F_FIRST_BIT], gn_fix};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Hold and decay share one 100 ms tick.
  assign tick = (tick_q == 24'(HOLD_STEP_CYC - 1));

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || tick)
      tick_q <= 24'h0;
    else
      tick_q <= tick_q + 24'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Per mic: reference choice, threshold test, candidate open.
  logic [7:0] lvl  [NUM_MICS];
  logic [NUM_MICS-1:0] above;
  logic [NUM_MICS-1:0] grouped;

  genvar gm;
  generate
    for (gm = 0; gm < NUM_MICS; gm++)
    begin : g_mic
      wire [3:0] grp   = mcfg_q[gm].grp;
      wire [4:0] rsel  = mlvl_q[gm].refsel[4:0];
      wire [7:0] rlvl  = ref_level_i[rsel*8 +: 8];                 // see [R13]
      wire       ract  = ref_active_i[rsel];                       // see [R14]
      wire [7:0] base  = mcfg_q[gm].adapt ? amb_q[gm]
                                          : mlvl_q[gm].amb;        // see [R06]
      wire [7:0] lsamb = (mcfg_q[gm].lsref && ract && rlvl < base)
                         ? rlvl : base;                            // see [R08]
      wire       use_g = (grp != GRP_NONE) && gcfg_q[grp[2:0]][F_FIRST_BIT]
                         && first_q[grp[2:0]];
      wire [7:0] gamb  = (use_g && grp_amb_q[grp[2:0]] < lsamb)
                         ? grp_amb_q[grp[2:0]] : lsamb;            // see [R18]
      wire [8:0] need  = {1'b0, gamb} - {1'b0, mcfg_q[gm].ratio};
      assign lvl[gm]   = mic_level_i[gm*8 +: 8];
      assign grouped[gm] = (grp != GRP_NONE);                      // see [R16]
      assign above[gm] = ~need[8] && (lvl[gm] <= need[7:0]);       // see [R09]
      assign want[gm]  = (mcfg_q[gm].mode == 2'(AMG_FORCE_ON)) ||
                         ((mcfg_q[gm].mode == 2'(AMG_AUTO)) &&
                          (above[gm] || hold_q[gm] != 8'h00));     // see [R02]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Group arbitration: override, open limit in mic order, last mic.
  always_comb
  begin
    logic [7:0] cnt [NUM_GROUPS];
    logic [NUM_GROUPS-1:0] ovr_on;
    logic [NUM_GROUPS-1:0] any;
    logic [2:0] g;
    for (int k = 0; k < NUM_GROUPS; k++)
      cnt[k] = 8'h00;
    ovr_on = '0;
    any    = '0;
    open_d = '0;
    g      = 3'h0;
    for (int m = 0; m < NUM_MICS; m++)
      if (want[m] && grouped[m] && mcfg_q[m].ovr)
        ovr_on[mcfg_q[m].grp[2:0]] = 1'b1;
    for (int m = 0; m < NUM_MICS; m++)
    begin
      g = mcfg_q[m].grp[2:0];
      if (!grouped[m])
        open_d[m] = want[m];                                       // see [R16]
      else if (want[m] && (mcfg_q[m].ovr || !ovr_on[g]) &&         // see [R05]
               (gcfg_q[g][7:0] == MAXN_ALL || cnt[g] < gcfg_q[g][7:0]))
      begin
        open_d[m] = 1'b1;                                          // see [R03]
        cnt[g]    = cnt[g] + 8'h01;                                // see [R17]
      end
      if (mcfg_q[m].mode == 2'(AMG_FORCE_OFF))
        open_d[m] = 1'b0;                                          // see [R04]
      if (grouped[m] && open_d[m])
        any[g] = 1'b1;
    end
    for (int m = 0; m < NUM_MICS; m++)
    begin
      g = mcfg_q[m].grp[2:0];
      if (grouped[m] && !any[g] && mcfg_q[m].mode != 2'(AMG_FORCE_OFF))
        unique case (gcfg_q[g][F_LAST_LSB +: 2])
          2'(AMG_LAST_ON):  open_d[m] = last_q[m];                 // see [R19]
          2'(AMG_LAST_MIC): open_d[m] = (gcfg_q[g][F_LASTMIC_LSB +: 3]
                                         == 3'(m));
          default:          open_d[m] = 1'b0;
        endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gate state, hold timers, adaptive ambient, first-opener capture.
  logic [NUM_MICS-1:0] newly;
  assign newly = open_d & ~open_q & want;

  always_ff @(posedge sys_clk_i)
  begin
    for (int m = 0; m < NUM_MICS; m++)
    begin
      if (rst_i)
      begin
        hold_q[m] <= 8'h00;
        amb_q[m]  <= MAX_AMB;
        last_q[m] <= 1'b0;
      end
      else
      begin
        if (above[m])
          hold_q[m] <= mcfg_q[m].hold;                             // see [R21]
        else if (tick && hold_q[m] != 8'h00)
          hold_q[m] <= hold_q[m] - 8'h01;                          // see [R10]
        // Slow rise toward quiet, fast follow of a lower floor is avoided
        // so speech does not drag the noise estimate up with it.
        if (tick && !open_q[m])
          amb_q[m] <= (lvl[m] < amb_q[m]) ? amb_q[m] - 8'h01
                      : amb_q[m] + {7'h00, amb_q[m] < 8'hff};      // see [R06]
        if (|newly && grouped[m])
          last_q[m] <= newly[m] || (last_q[m] && !(|(newly &
                       grp_mask(mcfg_q[m].grp))));
      end
    end
  end

  function automatic logic [NUM_MICS-1:0] grp_mask(input logic [3:0] grp);
    logic [NUM_MICS-1:0] r;
    r = '0;
    for (int k = 0; k < NUM_MICS; k++)
      r[k] = (mcfg_q[k].grp == grp);
    return r;
  endfunction

  always_ff @(posedge sys_clk_i)
  begin
    for (int g = 0; g < NUM_GROUPS; g++)
    begin
      if (rst_i)
      begin
        first_q[g]   <= 1'b0;
        grp_amb_q[g] <= 8'hff;
      end
      else if (!(|(open_q & want & grp_mask(4'(g)))))
        first_q[g] <= 1'b0;
      else if (!first_q[g])
      begin
        first_q[g]   <= 1'b1;                                      // see [R18]
        grp_amb_q[g] <= max_lvl(grp_mask(4'(g)));
      end
    end
  end

  // The quietest level any member hears when the first opens is the floor
  // the others must beat, so a single talker opens one mic.
  function automatic logic [7:0] max_lvl(input logic [NUM_MICS-1:0] msk);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < NUM_MICS; k++)
      if (msk[k] && lvl[k] > r)
        r = lvl[k];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Output gain: instant open, stepwise close toward off attenuation.
  function automatic logic [7:0] step(input logic [1:0] d);
    unique case (d)
      2'(AMG_SLOW): return 8'h01;
      2'(AMG_FAST): return 8'h0c;
      default:      return 8'h04;
    endcase
  endfunction

  always_ff @(posedge sys_clk_i)
  begin
    for (int m = 0; m < NUM_MICS; m++)
    begin
      if (rst_i)
        att_q[m] <= MIC_LVL_RST.offatt;
      else if (open_d[m])
        att_q[m] <= 8'h00;
      else if (tick)
        att_q[m] <= (att_q[m] + step(mcfg_q[m].decay) >= mlvl_q[m].offatt)
                    ? mlvl_q[m].offatt
                    : att_q[m] + step(mcfg_q[m].decay);            // see [R12]
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      open_q <= '0;
    else
      open_q <= open_d;
  end

  assign gate_on_o = open_q;

  generate
    for (gm = 0; gm < NUM_MICS; gm++)
    begin : g_out
      assign mic_atten_o[gm*8 +: 8] = att_q[gm];                   // see [R11]
    end
  endgenerate

endmodule

// ---- tb/amg_src.sv ----
`timescale 1ns/1ps
module amg_src
  import amg_pkg::*;
(
  input  wire logic                           sys_clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           load_i,
  input  wire logic [4:0]                     idx_i,
  input  wire logic [7:0]                     lvl_i,
  input  wire logic                           act_i,
  output logic      [amg_pkg::NUM_MICS*8-1:0] mic_level_o,
  output logic      [amg_pkg::NUM_REFS*8-1:0] ref_level_o,
  output logic      [amg_pkg::NUM_REFS-1:0]   ref_active_o
);
  // Indices below the mic count pick a mic, the rest pick a reference.
  // Silence is the idle level, so an unloaded auto mic cannot beat a nonzero ratio.
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      mic_level_o  <= '1;
      ref_level_o  <= '1;
      ref_active_o <= '0;
    end
    else if (load_i && idx_i < NUM_MICS)
      mic_level_o[idx_i*8 +: 8] <= lvl_i;
    else if (load_i)
    begin
      ref_level_o[(idx_i-NUM_MICS)*8 +: 8] <= lvl_i;
      ref_active_o[idx_i-NUM_MICS]          <= act_i;
    end
  end
endmodule

// ---- tb/amg_core_props.sv ----
`timescale 1ns/1ps
module amg_props
  import amg_pkg::*;
(
  input wire logic                           sys_clk_i,
  input wire logic                           rst_i,
  input wire logic [7:0]                     avs_address_i,
  input wire logic                           avs_read_i,
  input wire logic                           avs_write_i,
  input wire logic [31:0]                    avs_writedata_i,
  input wire logic [3:0]                     avs_byteenable_i,
  input wire logic [31:0]                    avs_readdata_o,
  input wire logic                           avs_waitrequest_o,
  input wire logic [1:0]                     avs_response_o,
  input wire logic [amg_pkg::NUM_MICS-1:0]   gate_on_o,
  input wire logic [amg_pkg::NUM_MICS*8-1:0] mic_atten_o
);
  // Shadow of mic 0 mode and group, clipped as the core clips them.
  logic [1:0] mode0_q;
  logic [3:0] grp0_q;
  wire wr0 = avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h00
             && avs_byteenable_i == 4'hf;
  wire [1:0] mode0_d = (avs_writedata_i[1:0] == 2'h3) ? 2'h0
                       : avs_writedata_i[1:0];
  wire [3:0] grp0_d = avs_writedata_i[8] ? 4'hf : avs_writedata_i[8:5];
  wire off0 = mode0_q == 2'h2;
  wire on0 = mode0_q == 2'h1 && grp0_q == 4'hf;
  wire auto0 = mode0_q == 2'h0 && grp0_q == 4'hf;
  always_ff @(posedge sys_clk_i)
  begin
    mode0_q <= rst_i ? 2'h0 : (wr0 ? mode0_d : mode0_q);
    grp0_q  <= rst_i ? 4'h4 : (wr0 ? grp0_d : grp0_q);
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req_start;
    $rose(avs_read_i || avs_write_i);
  endsequence
  sequence s_one_wait;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  chk_wait_once: assert property (s_req_start |-> s_one_wait)
    else $error("waitrequest did not drop after one cycle");
  chk_idle_nowait: assert property
    (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("waitrequest high without request");
  chk_unmapped_err: assert property (avs_read_i && !avs_waitrequest_o
    && avs_address_i > 8'h18 |-> avs_response_o == 2'h2
    && avs_readdata_o == 32'h0)
    else $error("unmapped read not refused");
  chk_mapped_ok: assert property (avs_read_i && !avs_waitrequest_o
    && avs_address_i <= 8'h18 |-> avs_response_o == 2'h0)
    else $error("mapped read not okay");
  chk_reset_shut: assert property ($fell(rst_i) |-> gate_on_o == '0
    && mic_atten_o == {NUM_MICS{8'h0c}})
    else $error("outputs wrong after reset");
  chk_forced_off: assert property (off0 && $past(off0)
    && $past(off0, 2) |-> !gate_on_o[0])
    else $error("forced-off mic open");
  chk_forced_on: assert property (on0 && $past(on0)
    && $past(on0, 2) |-> gate_on_o[0])
    else $error("ungrouped forced-on mic closed");
  chk_open_unatten: assert property ($rose(gate_on_o[0])
    |-> ##[0:2] mic_atten_o[7:0] == 8'h00)
    else $error("open mic still attenuated");
  chk_hold_open: assert property ($rose(gate_on_o[0]) && auto0
    |=> gate_on_o[0] [*8])
    else $error("auto gate closed before hold");
endmodule

bind amg_core amg_props i_amg_props (
  .sys_clk_i         (sys_clk_i),
  .rst_i             (rst_i),
  .avs_address_i     (avs_address_i),
  .avs_read_i        (avs_read_i),
  .avs_write_i       (avs_write_i),
  .avs_writedata_i   (avs_writedata_i),
  .avs_byteenable_i  (avs_byteenable_i),
  .avs_readdata_o    (avs_readdata_o),
  .avs_waitrequest_o (avs_waitrequest_o),
  .avs_response_o    (avs_response_o),
  .gate_on_o         (gate_on_o),
  .mic_atten_o       (mic_atten_o)
);

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import amg_pkg::*;
  logic        sys_clk, rst, rd, wr, load, act;
  logic [7:0]  addr, lvl;
  logic [4:0]  idx;
  logic [31:0] wdat, q;
  logic [1:0]  r;
  logic [31:0] rdat;
  logic        wreq;
  logic [1:0]  resp;
  logic [NUM_MICS-1:0]   gate;
  logic [NUM_MICS*8-1:0] mic_lvl, att;
  logic [NUM_REFS*8-1:0] ref_lvl;
  logic [NUM_REFS-1:0]   ref_act;
  int          err_total, checked, cycles;

  amg_core i_amg_core (.sys_clk_i(sys_clk), .rst_i(rst),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .avs_response_o(resp), .mic_level_i(mic_lvl), .ref_level_i(ref_lvl),
    .ref_active_i(ref_act), .gate_on_o(gate), .mic_atten_o(att));
  amg_src i_amg_src (.sys_clk_i(sys_clk), .rst_i(rst), .load_i(load),
    .idx_i(idx), .lvl_i(lvl), .act_i(act), .mic_level_o(mic_lvl),
    .ref_level_o(ref_lvl), .ref_active_o(ref_act));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // A hang anywhere is cut short here rather than by the simulator.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    logic busy;
    busy = 1'b1;
    wr <= w;
    rd <= !w;
    addr <= a;
    wdat <= d;
    while (busy)
    begin
      @(posedge sys_clk);
      busy = (wreq !== 1'b0);
    end
    q = rdat;
    r = resp;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("readdata", q, e);
  endtask
  task automatic src(input logic [4:0] i, input logic [7:0] l,
                     input logic a);
    load <= 1'b1;
    idx <= i;
    lvl <= l;
    act <= a;
    @(posedge sys_clk);
    load <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst, rd, wr, load, act} = 5'h10;
    {addr, lvl, idx, wdat} = '0;
    {err_total, checked, cycles} = '0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("gate after reset", gate, 32'h0);
    chk("atten after reset", att[31:0], 32'h0c0c_0c0c);
    rdc(8'h00, MIC_CFG_RST);
    rdc(8'h08, MIC_LVL_RST);
    rdc(8'h10, GRP_CFG_RST);
    rdc(8'h14, GRP_CFG_RST);
    rdc(8'h19, 32'h0);
    chk("unmapped response", r, 2'h2);
    // Out-of-range fields are clipped, not stored raw.
    bus(1'b1, 8'h07, 32'h0040_0723);
    rdc(8'h07, 32'h0132_03e0);
    bus(1'b1, 8'h0f, 32'h001e_603c);
    rdc(8'h0f, 32'h0013_5032);
    bus(1'b1, 8'h10, 32'h0000_0409);
    rdc(8'h10, 32'h0000_0008);
    // Mic 0 goes loud only once forced off, so it has never opened and
    // its attenuation still sits at the off level.
    src(5'd0, 8'hff, 1'b0);
    bus(1'b1, 8'h00, 32'h030f_01e2);
    src(5'd0, 8'h00, 1'b0);
    chk("off mic gate", gate[0], 1'b0);
    chk("off mic atten", att[7:0], 8'h0c);
    bus(1'b1, 8'h00, 32'h030f_01e1);
    src(5'd0, 8'h00, 1'b0);
    chk("on mic gate", gate[0], 1'b1);
    bus(1'b1, 8'h00, 32'h030f_01e2);
    src(5'd0, 8'h00, 1'b0);
    chk("off again gate", gate[0], 1'b0);
    bus(1'b1, 8'h00, 32'h030f_01e0);
    src(5'd0, 8'h00, 1'b0);
    chk("auto loud gate", gate[0], 1'b1);
    chk("auto loud atten", att[7:0], 8'h00);
    // Threshold is 80 - 15: level 65 opens, 66 stays shut.
    bus(1'b1, 8'h05, 32'h030f_01e0);
    bus(1'b1, 8'h06, 32'h030f_01e0);
    src(5'd5, 8'h42, 1'b0);
    src(5'd6, 8'h41, 1'b0);
    chk("ratio boundary", gate[6:5], 2'b10);
    // Three forced-on mics in a group limited to two.
    bus(1'b1, 8'h10, 32'h0000_0002);
    bus(1'b1, 8'h01, 32'h030f_0001);
    bus(1'b1, 8'h02, 32'h030f_0001);
    bus(1'b1, 8'h03, 32'h030f_0001);
    src(5'd3, 8'hff, 1'b0);
    chk("group limit", gate[3:1], 3'b011);
    // Override opener in group 1 shuts its plain neighbour.
    bus(1'b1, 8'h11, 32'h0000_0004);
    bus(1'b1, 8'h01, 32'h030f_0020);
    bus(1'b1, 8'h02, 32'h030f_0024);
    src(5'd1, 8'h00, 1'b0);
    chk("plain mic opens", gate[1], 1'b1);
    src(5'd2, 8'h00, 1'b0);
    chk("override", gate[3:1], 3'b110);
    // Active loudspeaker reference 3 raises the ambient for mic 4.
    bus(1'b1, 8'h0c, 32'h0003_500c);
    bus(1'b1, 8'h04, 32'h030f_01f0);
    src(5'd11, 8'h14, 1'b1);
    src(5'd4, 8'h1e, 1'b0);
    chk("ref active", gate[4], 1'b0);
    src(5'd11, 8'h14, 1'b0);
    chk("ref idle", gate[4], 1'b1);
    chk("gate vector", gate, 8'h5d);
    // Last openers: mic 3 in group 0, mic 2 in group 1.
    rdc(8'h18, 32'h0000_0c5d);
    report_and_stop();
  end
endmodule
